//--- hdl/btc_params.svh
// Purpose: Branch target cache constants.
// Assumes: Included by its bare name.
// Notes: Definitions only.
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH

// ==========================================================================
// Geometry
// ==========================================================================
`define BTC_SLOTS 63
`define BTC_LAST_SLOT 6'h3e
`define BTC_TAG_W 15
`define BTC_ADDR_W 17

// ==========================================================================
// Register offsets (byte addresses) and field positions
// ==========================================================================
`define BTC_CTRL_OFS 4'h0
`define BTC_TUNE_OFS 4'h4
`define BTC_LOCK_OFS 4'h8
`define BTC_STAT_OFS 4'hc
`define BTC_CTRL_WR_ALLOW 7
`define BTC_CTRL_RD_ALLOW 6
`define BTC_CTRL_PF_ALLOW 5
`define BTC_CTRL_CLEAR 4
`define BTC_CTRL_RETI 3
`define BTC_CTRL_ISR 2
`define BTC_CTRL_MOVC 1
`define BTC_CTRL_BLKW 0
`define BTC_TUNE_ALG 3
`define BTC_TUNE_FIXM 2
`define BTC_LOCK_PUSH 7
`define BTC_LOCK_POP 6

// ==========================================================================
// Reset values and timing
// ==========================================================================
`define BTC_CTRL_RST 8'he6
`define BTC_TUNE_RST 8'h04
`define BTC_LOCK_RST 8'h3e
`define BTC_LFSR_RST 7'h01
`define BTC_FLASH_ACCESS_NS 40
`define BTC_CLK_PERIOD_PS 25000

`endif

//--- hdl/btc_pkg.sv
// Purpose: Types shared by the branch target cache modules.
// Assumes: btc_params.svh supplies the widths.
// Notes: One state struct per module.
`include "btc_params.svh"

package btc_pkg;

   // ========================================================================
   // Fetch engine states
   // ========================================================================
   typedef enum logic [0:0] {
      BTC_IDLE = 1'b0,
      BTC_READ = 1'b1
   } btc_state_t;

   // ========================================================================
   // State of the cache top and of its picker
   // ========================================================================
   typedef struct packed {
      btc_state_t st;
      logic [2:0] cnt;
      logic [14:0] pf_grp;
      logic lin_valid;
      logic [14:0] lin_tag;
      logic [31:0] lin_data;
      logic [62:0] valid;
      logic [62:0][14:0] tag;
      logic [62:0][31:0] data;
      logic wr_allow;
      logic rd_allow;
      logic pf_allow;
      logic reti_en;
      logic isr_en;
      logic movc_en;
      logic blkw;
      logic alg;
      logic fixm;
      logic [1:0] thresh;
      logic push_en;
      logic [5:0] lock_ptr;
      logic wr_pend;
      logic [3:0] wr_ofs;
      logic [31:0] rdata;
      logic hreadyout;
      logic ack;
      logic [31:0] fdata;
      logic [2:0] stall_cnt;
      logic flash_rd;
      logic [14:0] flash_grp;
   } btc_core_t;

   typedef struct packed {
      logic dir;
      logic [5:0] reb;
      logic [6:0] lfsr;
   } btc_victim_t;

endpackage

//--- hdl/btc_victim_if.sv
// Purpose: Replacement requests to the picker.
// Assumes: One clock domain.
// Notes: The victim index is valid in every cycle.
`timescale 1ns/1ps

interface btc_victim_if;
   logic alg;
   logic [5:0] lock_ptr;
   logic advance;
   logic [5:0] victim;

   modport owner (output alg, output lock_ptr, output advance, input victim);
   modport picker (input alg, input lock_ptr, input advance, output victim);
endinterface

//--- hdl/btc_victim.sv
// Purpose: Chooses the slot that a normal cache fill replaces.
// Assumes: Slots above a nonzero pointer are locked.
// Notes: Rebound walk or LFSR folded into the unlocked range.
`timescale 1ns/1ps
`include "btc_params.svh"

module btc_victim (
   input wire logic core_clk_i,
   input wire logic reset_i,
   btc_victim_if.picker vif
);

   btc_pkg::btc_victim_t s_r;
   btc_pkg::btc_victim_t s_nxt;
   logic [5:0] limit;
   logic [5:0] rnd;

   // ========================================================================
   // Unlocked range and victim choice
   // ========================================================================
   // A zero pointer unlocks every slot.
   always_comb begin
      limit = (vif.lock_ptr == 6'h00) ? `BTC_LAST_SLOT : vif.lock_ptr; // see RULE_23 see RULE_20
      rnd = s_r.lfsr[5:0];
      if (rnd > limit) begin
         rnd = 6'(rnd - limit - 6'h01);
      end
      if (rnd > limit) begin
         rnd = limit;
      end
      if (vif.alg) begin
         vif.victim = rnd; // see RULE_09 see RULE_25
      end else begin
         vif.victim = (s_r.reb > limit) ? limit : s_r.reb; // see RULE_09
      end
   end

   // ========================================================================
   // Next state: LFSR every cycle, rebound only on a fill
   // ========================================================================
   always_comb begin
      s_nxt = s_r;
      s_nxt.lfsr = {s_r.lfsr[5:0], s_r.lfsr[6] ^ s_r.lfsr[5]}; // see RULE_25
      if (vif.advance) begin
         // Walk up to the end, then back down to the start.
         if (!s_r.dir) begin
            if (s_r.reb >= limit) begin
               s_nxt.dir = 1'b1;
               s_nxt.reb = 6'(limit - 6'h01);
            end else begin
               s_nxt.reb = 6'(s_r.reb + 6'h01);
            end
         end else begin
            if ((s_r.reb == 6'h00) || (s_r.reb > limit)) begin
               s_nxt.dir = 1'b0;
               s_nxt.reb = 6'h01;
            end else begin
               s_nxt.reb = 6'(s_r.reb - 6'h01);
            end
         end
      end
   end

   // Registered state.
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_r <= '{dir: 1'b0, reb: 6'h00, lfsr: `BTC_LFSR_RST};
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule // btc_victim

//--- hdl/btc_cache.sv
// Purpose: Branch target cache with a four-byte prefetch engine and lock stack.
// Assumes: Core holds its request until fetch_ack_o pulses.
// Notes: Flash answers a fixed count of cycles after a read.
//
// The implementer's own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "btc_params.svh"

// How it works
// RULE_01: 63 four-byte slots plus a prefetch buffer.
// RULE_02: Flash is read one four-byte group.
// RULE_03: A miss stalls the core four cycles most.
// RULE_04: Tags hold address bits 16..2 and valid.
// RULE_05: Requests match all valid tags, linear included.
// RULE_06: Match on group in flight waits for it.
// RULE_07: No match abandons prefetch, starts requested one.
// RULE_08: Qualifying fetched data fills the chosen slot.
// RULE_09: Replacement is rebound or pseudo-random by select.
// RULE_10: Writing clear bit empties the cache; the code keeps valid a slot fill or a prefetch parked in that same cycle.
// RULE_11: Fill only when stall exceeds the threshold.
// RULE_12: Return targets cached only when enabled.
// RULE_13: Handler code cached unless its bit cleared.
// RULE_14: Table reads gated; fixed slot sends them slot0.
// RULE_15: Write-allow gates fills, never lock pushes.
// RULE_16: Flash write or erase invalidates affected slots; a slot filled with that group in the same cycle stays valid.
// RULE_17: Read-allow off bypasses slots, fills continue.
// RULE_18: Prefetch-allow off stops the sequential prefetch.
// RULE_19: Push writes table group at pointer, decrements.
// RULE_20: Slots above the pointer never normally replaced.
// RULE_21: Pop increments pointer, keeps the slot data.
// RULE_22: Software locks at most 61, keeps 0,1 free.
// RULE_23: Pointer zero unlocks the entire cache.
// RULE_24: Software never pops at the reset pointer.
// RULE_25: Random slot comes from a free-running LFSR.
module btc_cache (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic fetch_req_i,
   input wire logic [16:0] fetch_addr_i,
   input wire logic fetch_movc_i,
   input wire logic fetch_reti_i,
   input wire logic fetch_isr_i,
   output logic fetch_ack_o,
   output logic [31:0] fetch_data_o,
   output logic flash_rd_o,
   output logic [14:0] flash_grp_o,
   input wire logic [31:0] flash_rdata_i,
   input wire logic flash_inval_i,
   input wire logic flash_inval_erase_i,
   input wire logic [16:0] flash_inval_addr_i
);

   // ========================================================================
   // Constants
   // ========================================================================
   // Flash access time rounded up to whole clock cycles.
   localparam int FLASH_CYC = (`BTC_FLASH_ACCESS_NS * 1000 + `BTC_CLK_PERIOD_PS - 1)
                              / `BTC_CLK_PERIOD_PS;
   localparam logic [2:0] FLASH_LAST = 3'(FLASH_CYC - 1);
   localparam logic [7:0] CTRL_RST = `BTC_CTRL_RST;
   localparam logic [7:0] TUNE_RST = `BTC_TUNE_RST;
   localparam logic [7:0] LOCK_RST = `BTC_LOCK_RST;
   localparam btc_pkg::btc_core_t CORE_RST = '{
      st: btc_pkg::BTC_IDLE,
      wr_allow: CTRL_RST[`BTC_CTRL_WR_ALLOW],
      rd_allow: CTRL_RST[`BTC_CTRL_RD_ALLOW],
      pf_allow: CTRL_RST[`BTC_CTRL_PF_ALLOW],
      reti_en: CTRL_RST[`BTC_CTRL_RETI],
      isr_en: CTRL_RST[`BTC_CTRL_ISR],
      movc_en: CTRL_RST[`BTC_CTRL_MOVC],
      blkw: CTRL_RST[`BTC_CTRL_BLKW],
      alg: TUNE_RST[`BTC_TUNE_ALG],
      fixm: TUNE_RST[`BTC_TUNE_FIXM],
      thresh: TUNE_RST[1:0],
      push_en: LOCK_RST[`BTC_LOCK_PUSH],
      lock_ptr: LOCK_RST[5:0],
      hreadyout: 1'b1,
      default: '0
   };

   // ========================================================================
   // Declarations
   // ========================================================================
   btc_pkg::btc_core_t s_r;
   btc_pkg::btc_core_t s_nxt;
   btc_victim_if vif ();
   logic [14:0] grp;
   logic [6:0] look;
   logic done;
   logic fill_ok;
   logic push;
   logic take;
   logic [31:0] ans;
   logic [5:0] slot;
   logic addr_ok;
   logic [31:0] wd;

   // Search of the slot tags; hit flag on top, slot index below.
   function automatic logic [6:0] btc_lookup(input logic [62:0] valid,
                                             input logic [62:0][14:0] tag,
                                             input logic [14:0] key);
      logic [6:0] res;
      res = 7'h00;
      for (int i = 0; i < `BTC_SLOTS; i++) begin
         if (valid[i] && (tag[i] == key)) begin
            res = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   // Register read value of a word offset.
   function automatic logic [31:0] btc_read(input btc_pkg::btc_core_t s,
                                            input logic [3:0] ofs);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (ofs)
         `BTC_CTRL_OFS: v[7:0] = {s.wr_allow, s.rd_allow, s.pf_allow, 1'b0,
                                  s.reti_en, s.isr_en, s.movc_en, s.blkw};
         `BTC_TUNE_OFS: v[3:0] = {s.alg, s.fixm, s.thresh};
         `BTC_LOCK_OFS: v[7:0] = {s.push_en, 1'b0, s.lock_ptr};
         `BTC_STAT_OFS: v[5:0] = {s.stall_cnt, s.lin_valid, s.flash_rd, s.ack};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // ========================================================================
   // Replacement picker
   // ========================================================================
   btc_victim u_victim (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .vif(vif.picker)
   );

   // ========================================================================
   // Next state
   // ========================================================================
   // Order: bus write, prefetch, core request, invalidation.
   // Invalidation comes last but tests the old slot tags, so a slot fill of a group being rewritten in that cycle survives; the linear slot does not.
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.hreadyout = 1'b1;
      grp = fetch_addr_i[16:2]; // see RULE_04
      look = btc_lookup(s_r.valid, s_r.tag, grp); // see RULE_05
      done = (s_r.st == btc_pkg::BTC_READ) && (s_r.cnt == FLASH_LAST);
      fill_ok = 1'b0;
      push = 1'b0;
      take = 1'b0;
      ans = 32'h0000_0000;
      slot = 6'h00;
      vif.advance = 1'b0;
      wd = hwdata_i;

      // Data phase of a bus write lands here.
      if (s_r.wr_pend) begin
         unique case (s_r.wr_ofs)
            `BTC_CTRL_OFS: begin
               s_nxt.wr_allow = wd[`BTC_CTRL_WR_ALLOW];
               s_nxt.rd_allow = wd[`BTC_CTRL_RD_ALLOW];
               s_nxt.pf_allow = wd[`BTC_CTRL_PF_ALLOW];
               s_nxt.reti_en = wd[`BTC_CTRL_RETI];
               s_nxt.isr_en = wd[`BTC_CTRL_ISR];
               s_nxt.movc_en = wd[`BTC_CTRL_MOVC];
               s_nxt.blkw = wd[`BTC_CTRL_BLKW];
               if (wd[`BTC_CTRL_CLEAR]) begin
                  s_nxt.valid = '0; // see RULE_10
                  s_nxt.lin_valid = 1'b0;
               end
            end
            `BTC_TUNE_OFS: begin
               s_nxt.alg = wd[`BTC_TUNE_ALG];
               s_nxt.fixm = wd[`BTC_TUNE_FIXM];
               s_nxt.thresh = wd[1:0];
            end
            `BTC_LOCK_OFS: begin
               s_nxt.push_en = wd[`BTC_LOCK_PUSH];
               if (wd[`BTC_LOCK_POP]) begin
                  s_nxt.lock_ptr = 6'(s_r.lock_ptr + 6'h01); // see RULE_21
               end
            end
            default: begin
            end
         endcase
      end

      // Flash read in flight: count cycles, then park the group in the linear slot.
      if (s_r.st == btc_pkg::BTC_READ) begin
         s_nxt.cnt = 3'(s_r.cnt + 3'h1);
         if (done) begin
            s_nxt.st = btc_pkg::BTC_IDLE;
            s_nxt.lin_valid = 1'b1;
            s_nxt.lin_tag = s_r.pf_grp;
            s_nxt.lin_data = flash_rdata_i; // see RULE_02
            // Straight-line code: read the following group ahead of use.
            if (s_r.pf_allow) begin
               s_nxt.st = btc_pkg::BTC_READ; // see RULE_18
               s_nxt.cnt = 3'h0;
               s_nxt.pf_grp = 15'(s_r.pf_grp + 15'h0001);
            end
         end
      end

      // Core request: hit, wait on the group in flight, or restart the read.
      if (fetch_req_i && !s_r.ack) begin
         if (done && (s_r.pf_grp == grp)) begin
            take = 1'b1; // see RULE_06
            ans = flash_rdata_i;
            // Only stalled requests are misses worth keeping.
            fill_ok = s_r.wr_allow && (s_r.stall_cnt > {1'b0, s_r.thresh}) // see RULE_11
                      && (!fetch_reti_i || s_r.reti_en) // see RULE_12
                      && (!fetch_isr_i || s_r.isr_en) // see RULE_13
                      && (!fetch_movc_i || s_r.movc_en); // see RULE_15 see RULE_14
         end else if (look[6] && s_r.rd_allow) begin
            take = 1'b1; // see RULE_05 see RULE_17
            ans = s_r.data[look[5:0]];
         end else if (s_r.lin_valid && (s_r.lin_tag == grp)) begin
            take = 1'b1; // see RULE_05
            ans = s_r.lin_data;
         end else if ((s_r.st == btc_pkg::BTC_READ) && (s_r.pf_grp == grp)) begin
            s_nxt.stall_cnt = 3'(s_r.stall_cnt + 3'h1); // see RULE_06 see RULE_03
         end else begin
            s_nxt.st = btc_pkg::BTC_READ; // see RULE_07
            s_nxt.cnt = 3'h0;
            s_nxt.pf_grp = grp;
            s_nxt.stall_cnt = 3'(s_r.stall_cnt + 3'h1);
         end
      end

      // Answer, then a lock push or a normal fill.
      if (take) begin
         s_nxt.ack = 1'b1;
         s_nxt.fdata = ans;
         s_nxt.stall_cnt = 3'h0;
         push = fetch_movc_i && s_r.push_en;
         if (push) begin
            slot = s_nxt.lock_ptr; // see RULE_19
            s_nxt.lock_ptr = 6'(s_nxt.lock_ptr - 6'h01);
         end else if (fill_ok) begin
            if (fetch_movc_i && s_r.fixm) begin
               slot = 6'h00; // see RULE_14
            end else begin
               slot = vif.victim; // see RULE_09 see RULE_20
               vif.advance = 1'b1;
            end
         end
         if (push || fill_ok) begin
            s_nxt.valid[slot] = 1'b1; // see RULE_08 see RULE_01
            s_nxt.tag[slot] = grp;
            s_nxt.data[slot] = ans;
         end
      end

      // A Flash write drops its group; an erase drops its whole 1 KiB page.
      if (flash_inval_i) begin
         for (int i = 0; i < `BTC_SLOTS; i++) begin
            if (flash_inval_erase_i ? (s_r.tag[i][14:8] == flash_inval_addr_i[16:10])
                                    : (s_r.tag[i] == flash_inval_addr_i[16:2])) begin
               s_nxt.valid[i] = 1'b0; // see RULE_16
            end
         end
         if (flash_inval_erase_i ? (s_nxt.lin_tag[14:8] == flash_inval_addr_i[16:10])
                                 : (s_nxt.lin_tag == flash_inval_addr_i[16:2])) begin
            s_nxt.lin_valid = 1'b0; // see RULE_16
         end
      end

      s_nxt.flash_rd = (s_nxt.st == btc_pkg::BTC_READ);
      s_nxt.flash_grp = s_nxt.pf_grp;

      // Bus address phase; read data comes from the next state so a write
      // directly ahead is already visible.
      addr_ok = (haddr_i[31:4] == 28'h0000000) && (haddr_i[1:0] == 2'b00);
      s_nxt.wr_pend = 1'b0;
      if (hsel_i && htrans_i[1] && hready_i) begin
         s_nxt.wr_pend = hwrite_i && addr_ok;
         s_nxt.wr_ofs = haddr_i[3:0];
         s_nxt.rdata = addr_ok ? btc_read(s_nxt, haddr_i[3:0]) : 32'h0000_0000;
      end
   end

   // Picker steering from current settings.
   assign vif.alg = s_r.alg;
   assign vif.lock_ptr = s_r.lock_ptr;

   // ========================================================================
   // State register
   // ========================================================================
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_r <= CORE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ========================================================================
   // Outputs
   // ========================================================================
   // All outputs come straight from the state register.
   assign hreadyout_o = s_r.hreadyout;
   assign hresp_o = 1'b0 & s_r.hreadyout;
   assign hrdata_o = s_r.rdata;
   assign fetch_ack_o = s_r.ack;
   assign fetch_data_o = s_r.fdata;
   assign flash_rd_o = s_r.flash_rd;
   assign flash_grp_o = s_r.flash_grp;

endmodule // btc_cache

//--- tb/btc_flash_model.sv
// Purpose: Program Flash, one whole group per read.
// Assumes: A group is readable on the second edge after it is put up.
// Notes: Between reads the data show garbage.
`timescale 1ns/1ps

module btc_flash_model (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic flash_rd_i,
   input wire logic [14:0] flash_grp_i,
   output logic [31:0] flash_rdata_o
);
   logic [14:0] grp_r;
   logic rd_r;

   // A group put up just now is not yet readable.
   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         grp_r <= 15'h0;
         rd_r <= 1'b0;
      end else begin
         grp_r <= flash_grp_i;
         rd_r <= flash_rd_i;
      end
   end

   // The group shows once it has stood an edge.
   assign flash_rdata_o = (flash_rd_i && rd_r && flash_grp_i == grp_r) ?
      {2'b01, flash_grp_i, ~flash_grp_i} : {2'b10, ~grp_r, grp_r};
endmodule // btc_flash_model

//--- tb/btc_cache_checker.sv
// Purpose: Concurrent checks on the ports of the cache top.
// Assumes: One clock; reset_i disables every check.
// Notes: Fetch answers watched from request to ack.
`timescale 1ns/1ps

module btc_cache_checker (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   input wire logic fetch_req_i,
   input wire logic [16:0] fetch_addr_i,
   input wire logic fetch_ack_o,
   input wire logic [31:0] fetch_data_o,
   input wire logic flash_rd_o,
   input wire logic [14:0] flash_grp_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   logic rd_take;

   // A qualified read address phase.
   assign rd_take = hsel_i && htrans_i[1] && hready_i && !hwrite_i;

   // Fetch answers: one caused pulse, within a four-cycle stall.
   ack_pulse_a: assert property (fetch_ack_o |=> !fetch_ack_o)
      else $error("fetch ack longer than one cycle");
   ack_cause_a: assert property (fetch_ack_o |-> $past(fetch_req_i))
      else $error("fetch ack without request");
   stall_bound_a: assert property ($rose(fetch_req_i) |-> ##[1:5] fetch_ack_o)
      else $error("fetch stalled too long");
   miss_fetch_a: assert property ($rose(fetch_req_i) ##1 !fetch_ack_o |->
      flash_rd_o && flash_grp_o == fetch_addr_i[16:2])
      else $error("miss did not read the requested group");
   data_hold_a: assert property (!fetch_ack_o |-> $stable(fetch_data_o))
      else $error("fetch data moved without ack");
   next_group_a: assert property (flash_rd_o && $past(flash_rd_o)
      && !$past(fetch_req_i) && flash_grp_o != $past(flash_grp_o)
      |-> flash_grp_o == $past(flash_grp_o) + 15'h1)
      else $error("prefetch skipped a group");
   bus_okay_a: assert property (hreadyout_o && !hresp_o)
      else $error("bus answer not ready and okay");
   clear_zero_a: assert property (rd_take && haddr_i == 32'h0 |=> !hrdata_o[4])
      else $error("clear bit read back as one");
   pop_zero_a: assert property (rd_take && haddr_i == 32'h8 |=> !hrdata_o[6])
      else $error("pop bit read back as one");

   // Main scenarios: hit, miss and register read.
   hit_c: cover property ($rose(fetch_req_i) ##1 fetch_ack_o);
   miss_c: cover property ($rose(fetch_req_i) ##1 !fetch_ack_o ##2 fetch_ack_o);
   read_c: cover property (rd_take);
endmodule // btc_cache_checker

bind btc_cache btc_cache_checker i_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
   .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .fetch_req_i(fetch_req_i),
   .fetch_addr_i(fetch_addr_i), .fetch_ack_o(fetch_ack_o), .fetch_data_o(fetch_data_o),
   .flash_rd_o(flash_rd_o), .flash_grp_o(flash_grp_o));

//--- tb/tb.sv
// Purpose: Self-checking bench for the branch target cache.
// Assumes: Register bus is AHB-Lite; the core side is driven by tasks.
// Notes: Latency in edges to the ack: hit 2, miss 4.
`timescale 1ns/1ps

// ==========================================================================
// Bench top
// ==========================================================================
module tb;
   localparam int HIT = 2;
   localparam int MISS = 4;
   // Case: control, tuning, {table,return,handler}, latency.
   localparam logic [31:0] CASES [10] = '{32'he6060004, 32'he6050002, 32'he6040204,
      32'hee040202, 32'he6040102, 32'he2040104, 32'he6040402, 32'he4040404,
      32'h66040004, 32'h86040004};
   logic core_clk_i = 1'b0;
   logic reset_i, hsel_i, hwrite_i, fetch_req_i, fetch_movc_i, fetch_reti_i, fetch_isr_i;
   logic flash_inval_i, hreadyout_o, fetch_ack_o, flash_rd_o;
   logic [1:0] htrans_i;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, fetch_data_o, flash_rdata_i;
   logic [16:0] fetch_addr_i, flash_inval_addr_i;
   logic [14:0] flash_grp_o;
   int error_cnt, samples_checked;

   // Clock of 25 ns.
   always #12.5 core_clk_i = ~core_clk_i;

   btc_cache i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .hsel_i(hsel_i),
      .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
      .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(),
      .hrdata_o(hrdata_o), .fetch_req_i(fetch_req_i), .fetch_addr_i(fetch_addr_i),
      .fetch_movc_i(fetch_movc_i), .fetch_reti_i(fetch_reti_i), .fetch_isr_i(fetch_isr_i),
      .fetch_ack_o(fetch_ack_o), .fetch_data_o(fetch_data_o), .flash_rd_o(flash_rd_o),
      .flash_grp_o(flash_grp_o), .flash_rdata_i(flash_rdata_i),
      .flash_inval_i(flash_inval_i), .flash_inval_erase_i(1'b0),
      .flash_inval_addr_i(flash_inval_addr_i));
   btc_flash_model i_flash (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .flash_rd_i(flash_rd_o), .flash_grp_i(flash_grp_o), .flash_rdata_o(flash_rdata_i));

   // ========================================================================
   // Tasks
   // ========================================================================
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   // Single AHB transfer; read data taken where the data phase ends.
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge core_clk_i);
      hsel_i <= 1'b1;
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
      q = hrdata_o;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   // Hold the request up to the ack; zero latency is unchecked.
   task automatic fetch(input logic [16:0] a, input logic [2:0] at, input int lat);
      int n;
      n = 0;
      @(posedge core_clk_i);
      fetch_addr_i <= a;
      {fetch_movc_i, fetch_reti_i, fetch_isr_i} <= at;
      fetch_req_i <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (fetch_ack_o !== 1'b1 && n < 10);
      fetch_req_i <= 1'b0;
      chk(fetch_data_o, {2'b01, a[16:2], ~a[16:2]});
      if (lat > 0) chk(32'(n), 32'(lat));
   endtask

   // Miss, evict the linear buffer, look again.
   task automatic refetch(input logic [16:0] a, input logic [2:0] at, input int lat);
      fetch(a, at, MISS);
      fetch(a ^ 17'h10000, 3'h0, 0);
      fetch(a, at, lat);
   endtask

   task automatic results();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ========================================================================
   // Tests
   // ========================================================================
   initial begin
      error_cnt = 0;
      samples_checked = 0;
      reset_i = 1'b1;
      {hsel_i, hwrite_i, fetch_req_i, fetch_movc_i, fetch_reti_i, fetch_isr_i} = 6'h0;
      {htrans_i, haddr_i, hwdata_i, fetch_addr_i, flash_inval_addr_i, flash_inval_i} = '0;
      repeat (2) @(posedge core_clk_i);
      reset_i <= 1'b0;
      rd(32'h0, 32'he6);
      rd(32'h4, 32'h4);
      rd(32'h8, 32'h3e);
      rd(32'h10, 32'h0);
      fetch(17'h100, 3'h0, MISS);
      fetch(17'h104, 3'h0, HIT);
      fetch(17'h100, 3'h0, HIT);
      for (int i = 0; i < 10; i++) begin
         wr(32'h0, {24'h0, CASES[i][31:24]});
         wr(32'h4, {24'h0, CASES[i][23:16]});
         refetch(17'h400 + 17'(i * 64), CASES[i][10:8], int'(CASES[i][7:0]));
      end
      wr(32'h0, 32'hc6);
      fetch(17'h700, 3'h0, MISS);
      fetch(17'h704, 3'h0, MISS);
      wr(32'h0, 32'hf6);
      fetch(17'h100, 3'h0, MISS);
      rd(32'h0, 32'he6);
      fetch(17'h1f00, 3'h0, 0);
      fetch(17'h100, 3'h0, HIT);
      @(posedge core_clk_i);
      flash_inval_addr_i <= 17'h102;
      flash_inval_i <= 1'b1;
      @(posedge core_clk_i);
      flash_inval_i <= 1'b0;
      fetch(17'h100, 3'h0, MISS);
      // Fills off: only the push keeps the table group.
      wr(32'h0, 32'h66);
      wr(32'h8, 32'h80);
      fetch(17'h900, 3'h4, MISS);
      rd(32'h8, 32'hbd);
      wr(32'h8, 32'h40);
      rd(32'h8, 32'h3e);
      fetch(17'h1900, 3'h0, 0);
      fetch(17'h900, 3'h0, HIT);
      results();
   end

   // Watchdog, over sixty times the test span.
   initial begin
      repeat (20000) @(posedge core_clk_i);
      error_cnt++;
      results();
   end
endmodule // tb
